/* File: rtl/mrcp_defs.svh */
// Constants of the multi-I/O read command path: opcodes, phase lengths,
// field positions and reset values.
// Assumes inclusion by bare name from the package and the read path module.
`ifndef MRCP_DEFS_SVH
`define MRCP_DEFS_SVH

// Opcodes decoded by the command phase.
`define MRCP_OP_DUAL_OUT 8'h3B
`define MRCP_OP_QUAD_OUT 8'h6B
`define MRCP_OP_QUAD_IO 8'hEB
`define MRCP_OP_SET_WRAP 8'h77
`define MRCP_OP_READ_PARAM 8'hC0
`define MRCP_OP_BURST_WRAP 8'h0C

// Phase lengths in link clocks.
`define MRCP_CMD_CLK_SINGLE 5'h08
`define MRCP_CMD_CLK_QUAD 5'h02
`define MRCP_ADDR_CLK_SINGLE 5'h18
`define MRCP_ADDR_CLK_QUAD 5'h06
`define MRCP_MODE_CLK 5'h02
`define MRCP_DUMMY_CLK_SINGLE 5'h08
`define MRCP_DUMMY_CLK_QIO_SPI 5'h04
`define MRCP_SET_WRAP_CLK 5'h08
`define MRCP_READ_PARAM_CLK 5'h02

// Dummy totals selected by the dummy count field.
`define MRCP_DUMMY_CODE0 5'h04
`define MRCP_DUMMY_CODE1 5'h02
`define MRCP_DUMMY_CODE2 5'h06
`define MRCP_DUMMY_CODE3 5'h08

// Field positions inside the configuration and mode bytes.
`define MRCP_WRAP_DIS_BIT 4
`define MRCP_WRAP_LEN_HI 6
`define MRCP_WRAP_LEN_LO 5
`define MRCP_PARAM_DUMMY_HI 5
`define MRCP_PARAM_DUMMY_LO 4
`define MRCP_PARAM_WRAP_HI 1
`define MRCP_PARAM_WRAP_LO 0
`define MRCP_MODE_CONT_HI 5
`define MRCP_MODE_CONT_LO 4
`define MRCP_MODE_CONT_VAL 2'h2

// Reset values of the read configuration.
`define MRCP_WRAP_DIS_RST 1'h1
`define MRCP_WRAP_LEN_RST 2'h0
`define MRCP_DUMMY_CODE_RST 2'h0

// Smallest wrap section in bytes.
`define MRCP_WRAP_BASE 7'h08

`endif

/* File: rtl/mrcp_pkg.sv */
// Types shared by the multi-I/O read command path and its bench.
// Assumes the constants header sits beside it on the include path.
`include "mrcp_defs.svh"

package mrcp_pkg;

   // Phases of one chip-select frame.
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_CFG,
      ST_IGNORE
   } mrcp_state_e;

   // Pins driven by the host controller.
   typedef struct packed {
      logic ce_n;
      logic sck;
      logic [3:0] io;
   } mrcp_pins_s;

   // Drive of the four data lines by the device.
   typedef struct packed {
      logic [3:0] io_out;
      logic [3:0] io_oe;
   } mrcp_drive_s;

   // Read configuration kept across frames.
   typedef struct packed {
      logic wrap_disable_bit;
      logic [1:0] wrap_length_field;
      logic [1:0] dummy_count_field;
   } mrcp_cfg_s;

endpackage

/* File: rtl/mrcp_byte_store.sv */
// Byte array read by the read command path.
// Assumes writes come from logic on the same clock; reads are registered.
`timescale 1ns/10ps

module mrcp_byte_store #(
   parameter int ADDR_W = 23
) (
   // Clock.
   input wire logic clk,
   // Preload port.
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   // Read port.
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [7:0] rd_data
);

   // The array itself; contents are undefined until written.
   logic [7:0] mem [0:(2**ADDR_W)-1];

   // Writes land on the clock edge.
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data comes out of a register, one clock after the address.
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

endmodule

/* File: rtl/mrcp_read_path.sv */
// Read command front end of a serial flash: multi-lane reads, continuous
// mode, wrapped bursts and read parameter setup.
// Assumes a host drives chip select and the link clock; both are sampled.
`timescale 1ns/10ps

`include "mrcp_defs.svh"

module mrcp_read_path #(
   parameter int ADDR_W = 23
) (
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   // Link pins from the host and drive back to them.
   input wire mrcp_pkg::mrcp_pins_s LINK,
   output mrcp_pkg::mrcp_drive_s DRIVE,
   // Device state and mode inputs from the same clock domain.
   input wire logic BUSY,
   input wire logic QUAD_ENABLE,
   input wire logic FOUR_WIRE_MODE,
   input wire logic RESET_CMD,
   // Configuration and mode status.
   output mrcp_pkg::mrcp_cfg_s CFG,
   output logic CONT_READ,
   // Array preload.
   input wire logic MEM_WR_EN,
   input wire logic [ADDR_W-1:0] MEM_WR_ADDR,
   input wire logic [7:0] MEM_WR_DATA
);

   import mrcp_pkg::*;

   // Synchroniser stages and previous values for edge detection.
   mrcp_pins_s link_s1;
   mrcp_pins_s link_s2;
   logic sck_d;
   logic ce_n_d;
   logic sck_rise;
   logic sck_fall;
   logic ce_fall;
   // Frame sequencer state.
   mrcp_state_e state;
   logic [4:0] cnt;
   logic [4:0] plen;
   logic [4:0] dummy_len;
   logic [7:0] op;
   logic [23:0] in_sh;
   logic [23:0] next_shift;
   logic quad_in;
   logic phase_done;
   logic [4:0] dummy_total;
   // Read data path.
   logic [ADDR_W-1:0] addr;
   logic [ADDR_W-1:0] next_addr;
   logic [ADDR_W-1:0] wmask;
   logic [7:0] rd_data;
   logic [7:0] out_sh;
   logic [3:0] out_left;
   logic [7:0] src;
   logic dual_out;
   logic wrap_on;
   logic load_byte;

   // Two flip-flops on every pin, then one more stage for edges.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         link_s1 <= '{ce_n: 1'b1, sck: 1'b0, io: 4'h0};
         link_s2 <= '{ce_n: 1'b1, sck: 1'b0, io: 4'h0};
         sck_d <= 1'b0;
         ce_n_d <= 1'b1;
      end else begin
         link_s1 <= LINK;
         link_s2 <= link_s1;
         sck_d <= link_s2.sck;
         ce_n_d <= link_s2.ce_n;
      end
   end

   // Edges seen only while the device is selected.
   assign sck_rise = !link_s2.ce_n && link_s2.sck && !sck_d;
   assign sck_fall = !link_s2.ce_n && !link_s2.sck && sck_d;
   assign ce_fall = !link_s2.ce_n && ce_n_d;

   // Dummy total for four-wire reads from the dummy count field.
   always_comb begin
      case (CFG.dummy_count_field)
         2'h0: dummy_total = `MRCP_DUMMY_CODE0;
         2'h1: dummy_total = `MRCP_DUMMY_CODE1;
         2'h2: dummy_total = `MRCP_DUMMY_CODE2;
         default: dummy_total = `MRCP_DUMMY_CODE3;
      endcase
   end

   // Phase length and lane count of the current input phase.
   always_comb begin
      plen = 5'h01;
      quad_in = 1'b1;
      case (state)
         ST_CMD: begin
            quad_in = FOUR_WIRE_MODE;
            plen = FOUR_WIRE_MODE ? `MRCP_CMD_CLK_QUAD : `MRCP_CMD_CLK_SINGLE;
         end
         ST_ADDR: begin
            // Quad I/O and every four-wire read take the address on four lines.
            quad_in = FOUR_WIRE_MODE || op == `MRCP_OP_QUAD_IO;
            plen = quad_in ? `MRCP_ADDR_CLK_QUAD : `MRCP_ADDR_CLK_SINGLE;
         end
         ST_MODE: plen = `MRCP_MODE_CLK;
         ST_DUMMY: plen = dummy_len;
         ST_CFG: begin
            // The wrap command carries 24 dummy bits before its wrap byte.
            plen = (op == `MRCP_OP_SET_WRAP) ? `MRCP_SET_WRAP_CLK
                                             : `MRCP_READ_PARAM_CLK;
         end
         default: plen = 5'h01;
      endcase
   end

   // Input bits sampled on a rising link edge, MSB first.
   assign next_shift = quad_in ? {in_sh[19:0], link_s2.io} : {in_sh[22:0], link_s2.io[0]};
   assign phase_done = sck_rise && (cnt == plen - 5'h01);

   // Frame sequencer: command, address, mode, dummy and data phases.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ST_IDLE;
         cnt <= 5'h00;
         op <= 8'h00;
         in_sh <= 24'h00_0000;
         dummy_len <= 5'h00;
      end else if (link_s2.ce_n) begin
         // Raising chip select ends any frame.
         state <= ST_IDLE;
         cnt <= 5'h00;
      end else if (ce_fall) begin
         cnt <= 5'h00;
         if (CONT_READ && BUSY) begin
            state <= ST_IGNORE;
         end else if (CONT_READ) begin
            // Continuous mode skips the opcode and starts with the address.
            state <= ST_ADDR;
            op <= `MRCP_OP_QUAD_IO;
         end else begin
            state <= ST_CMD;
         end
      end else if (sck_rise && state != ST_DATA && state != ST_IGNORE) begin
         in_sh <= next_shift;
         cnt <= phase_done ? 5'h00 : cnt + 5'h01;
         if (phase_done) begin
            case (state)
               ST_CMD: begin
                  op <= next_shift[7:0];
                  if (BUSY) begin
                     // A busy device drops the read and leaves its cycle alone.
                     state <= ST_IGNORE;
                  end else if (next_shift[7:0] == `MRCP_OP_DUAL_OUT && !FOUR_WIRE_MODE) begin
                     state <= ST_ADDR;
                  end else if (next_shift[7:0] == `MRCP_OP_QUAD_OUT && !FOUR_WIRE_MODE
                               && QUAD_ENABLE) begin
                     state <= ST_ADDR;
                  end else if (next_shift[7:0] == `MRCP_OP_QUAD_IO && QUAD_ENABLE) begin
                     state <= ST_ADDR;
                  end else if (next_shift[7:0] == `MRCP_OP_SET_WRAP && !FOUR_WIRE_MODE
                               && QUAD_ENABLE) begin
                     state <= ST_CFG;
                  end else if (next_shift[7:0] == `MRCP_OP_READ_PARAM && FOUR_WIRE_MODE) begin
                     state <= ST_CFG;
                  end else if (next_shift[7:0] == `MRCP_OP_BURST_WRAP && FOUR_WIRE_MODE) begin
                     state <= ST_ADDR;
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
               ST_ADDR: begin
                  if (op == `MRCP_OP_QUAD_IO) begin
                     state <= ST_MODE;
                  end else if (op == `MRCP_OP_BURST_WRAP) begin
                     dummy_len <= dummy_total;
                     state <= ST_DUMMY;
                  end else begin
                     dummy_len <= `MRCP_DUMMY_CLK_SINGLE;
                     state <= ST_DUMMY;
                  end
               end
               ST_MODE: begin
                  // In four-wire mode the mode clocks are part of the dummy total; SPI adds four dummies.
                  if (FOUR_WIRE_MODE && dummy_total == `MRCP_MODE_CLK) begin
                     state <= ST_DATA;
                  end else begin
                     dummy_len <= FOUR_WIRE_MODE ? dummy_total - `MRCP_MODE_CLK
                                                 : `MRCP_DUMMY_CLK_QIO_SPI;
                     state <= ST_DUMMY;
                  end
               end
               ST_DUMMY: state <= ST_DATA;
               default: state <= ST_IGNORE;
            endcase
         end
      end
   end

   // Continuous mode flag, judged from the mode byte of each quad I/O read.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CONT_READ <= 1'b0;
      end else if (RESET_CMD) begin
         CONT_READ <= 1'b0;
      end else if (phase_done && state == ST_MODE) begin
         // Any other value drops back to opcode decoding after this read.
         CONT_READ <= next_shift[`MRCP_MODE_CONT_HI:`MRCP_MODE_CONT_LO]
                      == `MRCP_MODE_CONT_VAL;
      end
   end

   // Read configuration written by the wrap and read parameter commands.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CFG <= '{wrap_disable_bit: `MRCP_WRAP_DIS_RST, wrap_length_field: `MRCP_WRAP_LEN_RST,
                  dummy_count_field: `MRCP_DUMMY_CODE_RST};
      end else if (RESET_CMD) begin
         CFG <= '{wrap_disable_bit: `MRCP_WRAP_DIS_RST, wrap_length_field: `MRCP_WRAP_LEN_RST,
                  dummy_count_field: `MRCP_DUMMY_CODE_RST};
      end else if (phase_done && state == ST_CFG) begin
         if (op == `MRCP_OP_SET_WRAP) begin
            // One shared length field, so a mode switch leaves it as set.
            CFG.wrap_disable_bit <= next_shift[`MRCP_WRAP_DIS_BIT];
            CFG.wrap_length_field <= next_shift[`MRCP_WRAP_LEN_HI:`MRCP_WRAP_LEN_LO];
         end else begin
            CFG.dummy_count_field <= next_shift[`MRCP_PARAM_DUMMY_HI:`MRCP_PARAM_DUMMY_LO];
            CFG.wrap_length_field <= next_shift[`MRCP_PARAM_WRAP_HI:`MRCP_PARAM_WRAP_LO];
         end
      end
   end

   // Wrap applies to SPI quad I/O reads with wrap enabled and to burst reads.
   assign wrap_on = (op == `MRCP_OP_QUAD_IO && !FOUR_WIRE_MODE && !CFG.wrap_disable_bit)
                    || op == `MRCP_OP_BURST_WRAP;
   assign wmask = ADDR_W'((`MRCP_WRAP_BASE << CFG.wrap_length_field) - 7'h01);
   assign next_addr = wrap_on ? ((addr & ~wmask) | ((addr + ADDR_W'(1)) & wmask))
                              : addr + ADDR_W'(1);
   assign dual_out = op == `MRCP_OP_DUAL_OUT;
   assign load_byte = sck_fall && state == ST_DATA && out_left == 4'h0;
   assign src = (out_left == 4'h0) ? rd_data : out_sh;

   // Byte array; the read address is the current read pointer.
   mrcp_byte_store #(
      .ADDR_W(ADDR_W)
   ) u_store (
      .clk(SYS_CLK),
      .wr_en(MEM_WR_EN),
      .wr_addr(MEM_WR_ADDR),
      .wr_data(MEM_WR_DATA),
      .rd_addr(addr),
      .rd_data(rd_data)
   );

   // Read pointer: loaded from the address phase, advanced per byte sent.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         addr <= '0;
      end else if (phase_done && state == ST_ADDR) begin
         addr <= next_shift[ADDR_W-1:0];
      end else if (load_byte) begin
         addr <= next_addr;
      end
   end

   // Data shifter and line drive, updated on falling link edges.
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         out_sh <= 8'h00;
         out_left <= 4'h0;
         DRIVE <= '{io_out: 4'h0, io_oe: 4'h0};
      end else if (state != ST_DATA) begin
         // Lines stay released until the first data edge.
         out_left <= 4'h0;
         DRIVE <= '{io_out: 4'h0, io_oe: 4'h0};
      end else if (sck_fall) begin
         if (dual_out) begin
            // Pairs of bits: first bit on IO1, second on IO0.
            DRIVE.io_out <= {2'h0, src[7:6]};
            DRIVE.io_oe <= 4'h3;
            out_sh <= {src[5:0], 2'h0};
            out_left <= (out_left == 4'h0) ? 4'h6 : out_left - 4'h2;
         end else begin
            // Nibbles: first bit on IO3 down to IO0.
            DRIVE.io_out <= src[7:4];
            DRIVE.io_oe <= 4'hF;
            out_sh <= {src[3:0], 4'h0};
            out_left <= (out_left == 4'h0) ? 4'h4 : out_left - 4'h4;
         end
      end
   end

   // A busy device never reaches the data phase of a new read.
   property p_busy_ignore;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      phase_done && state == ST_CMD && BUSY && !link_s2.ce_n |=> state == ST_IGNORE;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("read taken while busy");

   // Dual reads drive only the two low lines.
   property p_dual_lanes;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      state == ST_DATA && dual_out && DRIVE.io_oe != 4'h0 |-> DRIVE.io_oe == 4'h3;
   endproperty
   a_dual_lanes: assert property (p_dual_lanes) else $error("dual read drives wrong lines");

   // Without wrap the pointer advances by exactly one per byte.
   property p_addr_inc;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      load_byte && !wrap_on |=> addr == $past(addr) + ADDR_W'(1);
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("read address did not increment");

   // With wrap the pointer stays inside its aligned section.
   property p_wrap_stay;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      load_byte && wrap_on |=> (addr & ~wmask) == ($past(addr) & ~wmask);
   endproperty
   a_wrap_stay: assert property (p_wrap_stay) else $error("wrapped read left section");

   // Mode bits 10 in positions 5:4 raise the continuous flag.
   property p_cont_enter;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      phase_done && state == ST_MODE && !link_s2.ce_n && !RESET_CMD
         && next_shift[5:4] == 2'h2 |=> CONT_READ;
   endproperty
   a_cont_enter: assert property (p_cont_enter) else $error("continuous mode not entered");

   // Continuous mode starts the next frame at the address phase.
   property p_cont_skip;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      ce_fall && CONT_READ && !BUSY |=> state == ST_ADDR && op == `MRCP_OP_QUAD_IO;
   endproperty
   a_cont_skip: assert property (p_cont_skip) else $error("opcode not skipped");

   // Read parameters are refused in standard mode.
   property p_param_spi;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      phase_done && state == ST_CMD && !FOUR_WIRE_MODE && !link_s2.ce_n
         && next_shift[7:0] == `MRCP_OP_READ_PARAM |=> state == ST_IGNORE;
   endproperty
   a_param_spi: assert property (p_param_spi) else $error("read parameters taken in spi mode");

   // The reset command restores the default configuration.
   property p_reset_defaults;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      RESET_CMD |=> CFG.wrap_disable_bit && CFG.wrap_length_field == 2'h0
                    && CFG.dummy_count_field == 2'h0 && !CONT_READ;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("defaults lost");

   // Entering four-wire mode keeps the wrap length.
   property p_wrap_keep;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(FOUR_WIRE_MODE) && !RESET_CMD && !(phase_done && state == ST_CFG)
         |=> $stable(CFG.wrap_length_field);
   endproperty
   a_wrap_keep: assert property (p_wrap_keep) else $error("wrap length changed");

   // Data follows the last dummy clock directly.
   property p_data_after_dummy;
      @(posedge SYS_CLK) disable iff (!RESET_N)
      phase_done && state == ST_DUMMY && !link_s2.ce_n |=> state == ST_DATA;
   endproperty
   a_data_after_dummy: assert property (p_data_after_dummy) else $error("no data after dummies");

   // Main scenarios worth seeing.
   c_dual_data: cover property (@(posedge SYS_CLK) state == ST_DATA && dual_out && load_byte);
   c_cont_frame: cover property (@(posedge SYS_CLK) ce_fall && CONT_READ);
   c_wrap_turn: cover property (@(posedge SYS_CLK) load_byte && wrap_on
                                && (next_addr & wmask) == '0);
   c_param_set: cover property (@(posedge SYS_CLK) phase_done && state == ST_CFG
                                && op == `MRCP_OP_READ_PARAM);

endmodule

/* File: tb/mrcp_host_model.sv */
// Host controller model: drives chip select, link clock and lanes.
// Assumes the device updates its lanes within five system clocks of a fall.
`timescale 1ns/10ps
module mrcp_host_model (
   // Clock and device drive.
   input wire logic clk,
   input wire mrcp_pkg::mrcp_drive_s drv,
   // Pins seen by the device.
   output mrcp_pkg::mrcp_pins_s pins
);
   import mrcp_pkg::*;
   logic [3:0] host_io = 4'h0; // Lane levels the host drives.
   logic ce_n = 1'b1; // Chip select, active low.
   logic sck = 1'b0; // Link clock, idle low between frames.
   logic [7:0] rx; // Last byte received.
   logic oe_seen; // Set when the device drove any lane this frame.
   event byte_ev; // Fires when a byte is complete.
   // The device wins on lanes it enables.
   assign pins = {ce_n, sck, (drv.io_oe & drv.io_out) | (~drv.io_oe & host_io)};
   // One link clock: lanes change while low, sampled at the rise.
   task automatic tick(input logic [3:0] v, input bit rel, output logic [3:0] s);
      @(posedge clk) sck <= 1'b0;
      host_io <= rel ? ~host_io : v;
      repeat (5) @(posedge clk);
      sck <= 1'b1;
      s = pins.io;
      oe_seen = oe_seen | (|drv.io_oe);
      repeat (2) @(posedge clk);
   endtask
   // Sends n bits MSB first on one or four lanes.
   task automatic send(input logic [31:0] v, input int n, input int lanes);
      logic [3:0] s;
      for (int i = n - lanes; i >= 0; i -= lanes)
         tick(lanes == 4 ? v[i+:4] : {3'h0, v[i]}, 1'b0, s);
   endtask
   // Released clocks, used for dummies and ignored frames.
   task automatic idle(input int n);
      logic [3:0] s;
      repeat (n) tick(4'h0, 1'b1, s);
   endtask
   // Receives bytes on two or four lanes, highest lane first.
   task automatic recv(input int nb, input int lanes);
      logic [3:0] s;
      logic [7:0] b;
      repeat (nb) begin
         for (int k = 0; k < 8 / lanes; k++) begin
            tick(4'h0, 1'b1, s);
            b = (lanes == 4) ? {b[3:0], s} : {b[5:0], s[1:0]};
         end
         rx = b;
         ->byte_ev;
      end
   endtask
   // Frame start and end.
   task automatic open_frame();
      oe_seen = 1'b0;
      @(posedge clk) ce_n <= 1'b0;
   endtask
   task automatic close_frame();
      @(posedge clk) sck <= 1'b0;
      @(posedge clk) ce_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
endmodule

/* File: tb/mrcp_read_path_test.sv */
// Self-checking bench of the read command path.
// Assumes the host model file is compiled before this one.
`timescale 1ns/10ps
module mrcp_read_path_test;
   import mrcp_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic busy = 1'b0;
   logic quad_enable = 1'b0;
   logic four_wire_mode = 1'b0;
   logic reset_cmd = 1'b0;
   logic mem_wr_en = 1'b0;
   logic [9:0] mem_wr_addr = 10'h000;
   logic [7:0] mem_wr_data = 8'h00;
   mrcp_pins_s link;
   mrcp_drive_s drive;
   mrcp_cfg_s cfg;
   logic cont_read;
   logic [7:0] mem [1024]; // Bench copy of the array.
   logic [7:0] exp_q [$]; // Expected bytes in order.
   int n_errors = 0;
   int tests_run = 0;
   int seed = 41118;
   mrcp_read_path #(.ADDR_W(10)) dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .LINK(link),
      .DRIVE(drive), .BUSY(busy), .QUAD_ENABLE(quad_enable), .FOUR_WIRE_MODE(four_wire_mode),
      .RESET_CMD(reset_cmd), .CFG(cfg), .CONT_READ(cont_read), .MEM_WR_EN(mem_wr_en),
      .MEM_WR_ADDR(mem_wr_addr), .MEM_WR_DATA(mem_wr_data));
   mrcp_host_model host (.clk(sys_clk), .drv(drive), .pins(link));
   initial forever #10 sys_clk = ~sys_clk;
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      tests_run++;
      if (got !== want) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic conclude();
      if (n_errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Notes n bytes from address a; m masks the bits that count within a section.
   task automatic expect_bytes(input logic [9:0] a, input int n, input logic [9:0] m);
      for (int i = 0; i < n; i++)
         exp_q.push_back(mem[(a & ~m) | ((a + 10'(i)) & m)]);
   endtask
   // Single-line header: opcode, address and eight dummy clocks.
   task automatic spi_head(input logic [7:0] op, input logic [9:0] a);
      host.open_frame();
      host.send(op, 8, 1);
      host.send(a, 24, 1);
      host.send(8'h00, 8, 1);
   endtask
   // Each received byte is compared with the oldest note.
   always @(host.byte_ev)
      check(host.rx, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   initial begin
      #1ms;
      n_errors++;
      conclude();
   end
   initial begin
      for (int i = 0; i < 1024; i++)
         mem[i] = 8'($random(seed));
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 1024; i++) begin
         @(posedge sys_clk);
         mem_wr_en <= 1'b1;
         mem_wr_addr <= 10'(i);
         mem_wr_data <= mem[i];
      end
      @(posedge sys_clk) mem_wr_en <= 1'b0;
      check(8'(cfg), 8'h10);
      // Dual read across the top of the array.
      expect_bytes(10'h3FE, 3, 10'h3FF);
      spi_head(8'h3B, 10'h3FE);
      host.recv(3, 2);
      host.close_frame();
      // A read while busy is ignored and leaves the lanes alone.
      busy <= 1'b1;
      spi_head(8'h3B, 10'h000);
      host.idle(8);
      host.close_frame();
      check(8'(host.oe_seen), 8'h00);
      busy <= 1'b0;
      quad_enable <= 1'b1;
      expect_bytes(10'h010, 2, 10'h3FF);
      spi_head(8'h6B, 10'h010);
      host.recv(2, 4);
      host.close_frame();
      // Wrap on, sixteen-byte section.
      host.open_frame();
      host.send(8'h77, 8, 1);
      host.send(32'h0000_0020, 32, 4);
      host.close_frame();
      check(8'(cfg), 8'h04);
      expect_bytes(10'h02E, 4, 10'h00F);
      host.open_frame();
      host.send(8'hEB, 8, 1);
      host.send(10'h02E, 24, 4);
      host.send(8'h20, 8, 4);
      host.idle(4);
      host.recv(4, 4);
      host.close_frame();
      check(8'(cont_read), 8'h01);
      // Continuous frame starts at the address; other mode bits leave.
      expect_bytes(10'h01E, 3, 10'h00F);
      host.open_frame();
      host.send(10'h01E, 24, 4);
      host.send(8'hD5, 8, 4);
      host.idle(4);
      host.recv(3, 4);
      host.close_frame();
      check(8'(cont_read), 8'h00);
      // Parameter command is refused in standard mode.
      host.open_frame();
      host.send(8'hC0, 8, 1);
      host.send(8'h13, 8, 4);
      host.close_frame();
      check(8'(cfg), 8'h04);
      four_wire_mode <= 1'b1;
      host.open_frame();
      host.send(16'hC013, 16, 4);
      host.close_frame();
      check(8'(cfg), 8'h0D);
      // Two dummies all taken by the mode byte, which enters continuous mode; no wrap here.
      expect_bytes(10'h03E, 3, 10'h3FF);
      host.open_frame();
      host.send(8'hEB, 8, 4);
      host.send(10'h03E, 24, 4);
      host.send(8'h20, 8, 4);
      host.recv(3, 4);
      host.close_frame();
      check(8'(exp_q.size()), 8'h00);
      check(8'(cont_read), 8'h01);
      // A continuous frame that starts while busy is ignored as well.
      busy <= 1'b1;
      host.open_frame();
      host.send(10'h03E, 24, 4);
      host.idle(8);
      host.close_frame();
      check(8'(host.oe_seen), 8'h00);
      busy <= 1'b0;
      reset_cmd <= 1'b1;
      @(posedge sys_clk) reset_cmd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check(8'(cfg), 8'h10);
      check(8'(cont_read), 8'h00);
      // Burst read with the default four dummies and eight-byte wrap.
      expect_bytes(10'h05E, 3, 10'h007);
      host.open_frame();
      host.send(8'h0C, 8, 4);
      host.send(10'h05E, 24, 4);
      host.idle(4);
      host.recv(3, 4);
      host.close_frame();
      check(8'(exp_q.size()), 8'h00);
      conclude();
   end
endmodule
